// ==== tb_xcp_top.sv ====
// tb_xcp_top: self-checking bench for xcp_top
// assumes xcp_lock_model stands in for the clock manager
`timescale 1ns/1ns

module tb_xcp_top;
  logic aclk = 1'h0, aresetn = 1'h0, lose = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, s;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_elastic_bypass;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_clk_src, rx_clk_src, core_clk_rate;
  logic [1:0] r;
  logic mixed_mode_clock_manager_locked, mixed_mode_clock_manager_enable;
  logic [xcp_pkg::N_DOM-1:0] dom_rst_n;
  int error_cnt = 0, tests_run = 0;
  // {cfg, bypass, mgr, rate, rx src, tx src}
  logic [15:0] rows [14] = '{16'h0010, 16'h2220, 16'h0A20, 16'h0510,
    16'h1550, 16'h3550, 16'h2510, 16'h0D10, 16'h0710, 16'h0105,
    16'h0989, 16'h0305, 16'h0B89, 16'h3105};
  // {cfg ok, ref ok} per row
  logic [1:0] oks [14] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3,
    2'h3, 2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

  xcp_top i_dut (.*);
  xcp_lock_model #(.LOCK_CYC(6)) i_lock (.aclk(aclk),
    .enable(mixed_mode_clock_manager_enable), .lose(lose),
    .locked(mixed_mode_clock_manager_locked));

  initial begin
    forever #10 aclk = ~aclk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk

  // idle edge first so a ready lowered at the last edge is not re-raised
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
    if (n == 50) begin
      chk(1'h0, "write hang");
      finish_test();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
    if (n == 50) begin
      chk(1'h0, "read hang");
      finish_test();
    end
  endtask : axi_rd

  task automatic wait_dom(input logic [3:0] e);
    int n;
    for (n = 0; n < 30 && dom_rst_n !== e; n++) @(posedge aclk);
    chk(dom_rst_n === e, "domain reset state");
    // a stuck domain ends the run rather than cascading
    if (dom_rst_n !== e) finish_test();
  endtask : wait_dom

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      axi_wr(xcp_pkg::ADDR_CFG, {24'h0, rows[i][15:8]});
      axi_rd(xcp_pkg::ADDR_STAT);
      chk({d[9:8], d[5:0]} === rows[i][7:0], "status");
      chk(d[7:6] === oks[i], "reference legality");
      chk({rx_elastic_bypass, mixed_mode_clock_manager_enable,
        core_clk_rate, rx_clk_src, tx_clk_src} === rows[i][7:0], "plan");
    end
    axi_wr(xcp_pkg::ADDR_CFG, 32'h0);
    wait_dom(4'hF);
    axi_wr(xcp_pkg::ADDR_RST, 32'h5);
    wait_dom(4'hA);
    axi_rd(xcp_pkg::ADDR_RST);
    chk(d === 32'h5, "rst readback");
    axi_wr(xcp_pkg::ADDR_RST, 32'h0);
    chk(dom_rst_n === 4'hA, "early release");
    wait_dom(4'hF);
    // manager needed at 161.13: core held until lock
    axi_wr(xcp_pkg::ADDR_CFG, 32'h15);
    wait_dom(4'hF);
    lose <= 1'h1;
    wait_dom(4'hE);
    axi_rd(xcp_pkg::ADDR_STAT);
    chk(d[10] === 1'h0 && d[15:12] === 4'h1, "lock status");
    lose <= 1'h0;
    wait_dom(4'hF);
    axi_wr(8'h0C, 32'hFFFF_FFFF);
    chk(r === xcp_pkg::RESP_SLVERR, "unmapped write");
    axi_rd(8'h0C);
    chk(r === xcp_pkg::RESP_SLVERR && d === 32'h0, "unmapped read");
    axi_rd(xcp_pkg::ADDR_STAT);
    s = d;
    axi_wr(xcp_pkg::ADDR_STAT, ~s);
    chk(r === xcp_pkg::RESP_OKAY, "status write");
    axi_rd(xcp_pkg::ADDR_STAT);
    chk(d === s, "status changed");
    // second reset in mid-run
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    chk(dom_rst_n === 4'h0 && core_clk_rate === 2'h0, "reset");
    axi_rd(xcp_pkg::ADDR_CFG);
    chk(d === xcp_pkg::CFG_RST_VAL, "cfg reset value");
    axi_rd(xcp_pkg::ADDR_RST);
    chk(d === xcp_pkg::RST_RST_VAL, "rst reset value");
    finish_test();
  end
endmodule : tb_xcp_top

// ==== xcp_dom_if.sv ====
// xcp_dom_if: per-domain reset request and reset state
// assumes both ends run on the same register clock
`timescale 1ns/1ns

interface xcp_dom_if #(
  parameter int N = 4
);
  logic [N-1:0] req;
  logic [N-1:0] rst_n;
  modport ctrl (output req, input rst_n);
  modport bank (input req, output rst_n);
endinterface : xcp_dom_if

// ==== xcp_lock_model.sv ====
// xcp_lock_model: clock manager stand-in driving the lock pin
// assumes enable comes from the dut on the same aclk
`timescale 1ns/1ns

module xcp_lock_model #(
  parameter int LOCK_CYC = 6
) (
  input wire logic aclk,
  input wire logic enable,
  input wire logic lose,
  output logic locked
);
  int cnt;
  // settle time before lock, loss is at once
  always_ff @(posedge aclk) begin
    if (!enable || lose) begin
      cnt <= 0;
      locked <= 1'h0;
    end else if (cnt < LOCK_CYC) begin
      cnt <= cnt + 1;
    end else begin
      locked <= 1'h1;
    end
  end
endmodule : xcp_lock_model

// ==== xcp_pkg.sv ====
// xcp_pkg: constants and types for the xgmii clock plan block
// assumes a single 50 MHz register clock and an axi4-lite master

package xcp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
  localparam logic [31:0] CFG_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] RST_RST_VAL = 32'h0000_0000;

  // cfg fields
  localparam int CFG_FAM_NEW = 0;
  localparam int CFG_W32 = 1;
  localparam int CFG_KR = 2;
  localparam int CFG_BYP = 3;
  localparam int CFG_REF_LSB = 4;

  // status fields
  localparam int ST_TX_LSB = 0;
  localparam int ST_RX_LSB = 2;
  localparam int ST_CORE_LSB = 4;
  localparam int ST_REF_OK = 6;
  localparam int ST_CFG_OK = 7;
  localparam int ST_MGR = 8;
  localparam int ST_BYP = 9;
  localparam int ST_LOCK = 10;
  localparam int ST_DOM_LSB = 12;

  // ---------------------------------------------------------------
  // domains and answers
  // ---------------------------------------------------------------
  localparam int N_DOM = 4;
  localparam int DOM_CORE = 0;
  localparam int DOM_TXU = 1;
  localparam int DOM_RXU = 2;
  localparam int DOM_MGMT = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRC_CORE, SRC_TXU_HALF, SRC_RX_REC} xcp_src_t;
  typedef enum logic [1:0] {
    REF_156_25, REF_161_13, REF_312_5, REF_322_26
  } xcp_ref_t;
  typedef enum logic [1:0] {CORE_NONE, CORE_156_25, CORE_312_5} xcp_core_t;

endpackage : xcp_pkg

// ==== xcp_rst_bank.sv ====
// xcp_rst_bank: one reset synchroniser per clock domain
// assumes requests come from logic on the same clock
`timescale 1ns/1ns

module xcp_rst_bank #(
  parameter int N = 4,
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  xcp_dom_if.bank dom
);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("xcp_rst_bank needs at least two stages");
  end

  typedef struct packed {
    logic [STAGES-1:0][N-1:0] sh;
  } xcp_rb_st_t;

  xcp_rb_st_t st_ff;
  xcp_rb_st_t nxt_st;

  // ---------------------------------------------------------------
  // release chain
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st.sh[0] = {N{1'b1}};
    for (int s = 1; s < STAGES; s++) begin
      nxt_st.sh[s] = st_ff.sh[s-1];
    end
    for (int d = 0; d < N; d++) begin
      if (dom.req[d]) begin
        for (int s = 0; s < STAGES; s++) begin
          nxt_st.sh[s][d] = 1'b0; // [RULE12]
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // assert at once, release only from the last stage
  assign dom.rst_n = st_ff.sh[STAGES-1] & ~dom.req; // [RULE12]

endmodule : xcp_rst_bank

// ==== xcp_top.sv ====
// xcp_top: xgmii clock source plan and per-domain reset control
// assumes an axi4-lite master on aclk and a clock manager lock pin
//
// What this block does
// [RULE1] older family reference: 156.25, or 312.5 32-bit
// [RULE2] newer family reference: one of four fixed rates
// [RULE3] older family user clocks 322.26 from transceiver
// [RULE4] older 64-bit: xgmii on 156.25 core clock
// [RULE5] older 32-bit: xgmii on 312.5 core clock
// [RULE6] management clock at any reconfig port rate
// [RULE7] newer kr: 156.25 core clock, manager if needed
// [RULE8] kr builds never bypass receive elastic buffer
// [RULE9] newer r: transmit xgmii on tx user clock
// [RULE10] newer r: receive follows buffer presence choice
// [RULE11] each register reset synchronised to its domain; every chain here is clocked by aclk
// [RULE12] reset asserts at once, releases through two flops
`timescale 1ns/1ns

module xcp_top #(
  parameter int AW = xcp_pkg::ADDR_W,
  parameter int STAGES = xcp_pkg::SYNC_STAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mixed_mode_clock_manager_locked,
  output logic [1:0] tx_clk_src,
  output logic [1:0] rx_clk_src,
  output logic [1:0] core_clk_rate,
  output logic mixed_mode_clock_manager_enable,
  output logic rx_elastic_bypass,
  output logic [xcp_pkg::N_DOM-1:0] dom_rst_n
);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  if (AW < 4) begin : g_bad_aw
    $error("xcp_top needs at least four address bits");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [AW-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fam_new;
    logic w32;
    logic kr;
    logic byp;
    xcp_pkg::xcp_ref_t ref_sel;
    logic [xcp_pkg::N_DOM-1:0] rst_sw;
    logic cfg_chg;
    logic [2:0] lock_sh;
    logic lock_ok;
    xcp_pkg::xcp_src_t tx_src;
    xcp_pkg::xcp_src_t rx_src;
    xcp_pkg::xcp_core_t core_clk;
    logic ref_ok;
    logic cfg_ok;
    logic mgr_need;
    logic byp_eff;
  } xcp_top_st_t;

  xcp_top_st_t st_ff;
  xcp_top_st_t nxt_st;

  xcp_dom_if #(.N(xcp_pkg::N_DOM)) dom ();

  logic [xcp_pkg::N_DOM-1:0] nxt_req;
  logic [31:0] cfg_word;
  logic [31:0] wr_word;
  logic wr_go;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(
    input logic [AW-1:0] a,
    input logic [AW-1:0] off
  );
    hit = (a == off);
  endfunction : hit

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = data[b*8 +: 8];
      end
    end
  endfunction : merge

  // ---------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------
  always_comb begin
    cfg_word = xcp_pkg::CFG_RST_VAL;
    cfg_word[xcp_pkg::CFG_FAM_NEW] = st_ff.fam_new;
    cfg_word[xcp_pkg::CFG_W32] = st_ff.w32;
    cfg_word[xcp_pkg::CFG_KR] = st_ff.kr;
    cfg_word[xcp_pkg::CFG_BYP] = st_ff.byp;
    cfg_word[xcp_pkg::CFG_REF_LSB +: 2] = st_ff.ref_sel;
  end

  function automatic logic [31:0] rd_mux(
    input xcp_top_st_t s,
    input logic [31:0] cfg,
    input logic [xcp_pkg::N_DOM-1:0] rst_n,
    input logic [AW-1:0] a
  );
    rd_mux = '0;
    if (hit(a, AW'(xcp_pkg::ADDR_CFG))) begin
      rd_mux = cfg;
    end else if (hit(a, AW'(xcp_pkg::ADDR_RST))) begin
      rd_mux[xcp_pkg::N_DOM-1:0] = s.rst_sw;
    end else if (hit(a, AW'(xcp_pkg::ADDR_STAT))) begin
      rd_mux[xcp_pkg::ST_TX_LSB +: 2] = s.tx_src;
      rd_mux[xcp_pkg::ST_RX_LSB +: 2] = s.rx_src;
      rd_mux[xcp_pkg::ST_CORE_LSB +: 2] = s.core_clk;
      rd_mux[xcp_pkg::ST_REF_OK] = s.ref_ok;
      rd_mux[xcp_pkg::ST_CFG_OK] = s.cfg_ok;
      rd_mux[xcp_pkg::ST_MGR] = s.mgr_need;
      rd_mux[xcp_pkg::ST_BYP] = s.byp_eff;
      rd_mux[xcp_pkg::ST_LOCK] = s.lock_ok;
      rd_mux[xcp_pkg::ST_DOM_LSB +: xcp_pkg::N_DOM] = ~rst_n;
    end
  endfunction : rd_mux

  function automatic logic mapped(input logic [AW-1:0] a);
    mapped = hit(a, AW'(xcp_pkg::ADDR_CFG))
      || hit(a, AW'(xcp_pkg::ADDR_RST))
      || hit(a, AW'(xcp_pkg::ADDR_STAT));
  endfunction : mapped

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  // one write and one read outstanding keeps the slave small
  assign s_axi_awready = !st_ff.aw_have && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_have && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cfg_chg = 1'b0;
    wr_word = '0;

    // write channel
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    wr_go = nxt_st.aw_have && nxt_st.w_have;
    if (wr_go) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = mapped(nxt_st.aw_addr)
        ? xcp_pkg::RESP_OKAY : xcp_pkg::RESP_SLVERR;
      if (hit(nxt_st.aw_addr, AW'(xcp_pkg::ADDR_CFG))) begin
        wr_word = merge(cfg_word, nxt_st.w_data, nxt_st.w_strb);
        nxt_st.fam_new = wr_word[xcp_pkg::CFG_FAM_NEW];
        nxt_st.w32 = wr_word[xcp_pkg::CFG_W32];
        nxt_st.kr = wr_word[xcp_pkg::CFG_KR];
        nxt_st.byp = wr_word[xcp_pkg::CFG_BYP];
        nxt_st.ref_sel =
          xcp_pkg::xcp_ref_t'(wr_word[xcp_pkg::CFG_REF_LSB +: 2]);
        nxt_st.cfg_chg = 1'b1;
      end else if (hit(nxt_st.aw_addr, AW'(xcp_pkg::ADDR_RST))) begin
        wr_word = merge({28'h0000000, st_ff.rst_sw},
          nxt_st.w_data, nxt_st.w_strb);
        nxt_st.rst_sw = wr_word[xcp_pkg::N_DOM-1:0];
      end
    end

    // read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_mux(st_ff, cfg_word, dom.rst_n, s_axi_araddr);
      nxt_st.rresp = mapped(s_axi_araddr)
        ? xcp_pkg::RESP_OKAY : xcp_pkg::RESP_SLVERR;
    end

    // lock pin: a change counts once stages two and three agree
    nxt_st.lock_sh = {st_ff.lock_sh[1:0],
      mixed_mode_clock_manager_locked};
    if (st_ff.lock_sh[1] == st_ff.lock_sh[2]) begin
      nxt_st.lock_ok = st_ff.lock_sh[2];
    end

    // reference legality, derived from the written choice
    if (st_ff.fam_new) begin
      nxt_st.ref_ok = 1'b1;
    end else if (st_ff.w32) begin
      nxt_st.ref_ok = (st_ff.ref_sel == xcp_pkg::REF_312_5);
    end else begin
      nxt_st.ref_ok = (st_ff.ref_sel == xcp_pkg::REF_156_25);
    end
    // kr has only the 64-bit datapath
    nxt_st.cfg_ok = nxt_st.ref_ok && !(st_ff.kr && st_ff.w32);

    // buffer can never be dropped in kr builds
    nxt_st.byp_eff = st_ff.fam_new && !st_ff.kr && st_ff.byp; // [RULE8]

    // clock manager only when the reference cannot feed 156.25
    nxt_st.mgr_need = st_ff.fam_new && st_ff.kr
      && (st_ff.ref_sel != xcp_pkg::REF_156_25)
      && (st_ff.ref_sel != xcp_pkg::REF_312_5);

    // xgmii clock sources per family, width and variant
    if (!st_ff.fam_new) begin
      nxt_st.tx_src = xcp_pkg::SRC_CORE; // [RULE4] [RULE5]
      nxt_st.rx_src = xcp_pkg::SRC_CORE; // [RULE4] [RULE5]
      nxt_st.core_clk = st_ff.w32
        ? xcp_pkg::CORE_312_5 // [RULE5]
        : xcp_pkg::CORE_156_25; // [RULE4]
    end else if (st_ff.kr) begin
      nxt_st.tx_src = xcp_pkg::SRC_CORE;
      nxt_st.rx_src = xcp_pkg::SRC_CORE;
      nxt_st.core_clk = xcp_pkg::CORE_156_25;
    end else begin
      nxt_st.tx_src = xcp_pkg::SRC_TXU_HALF; // [RULE9]
      nxt_st.rx_src = nxt_st.byp_eff
        ? xcp_pkg::SRC_RX_REC // [RULE10]
        : xcp_pkg::SRC_TXU_HALF; // [RULE10]
      // no core clock in the xgmii path here
      nxt_st.core_clk = xcp_pkg::CORE_NONE;
    end
  end

  // ---------------------------------------------------------------
  // domain reset requests
  // ---------------------------------------------------------------
  // a re-muxed clock must not meet live registers, so any cfg
  // write or illegal choice holds every domain in reset
  always_comb begin
    for (int d = 0; d < xcp_pkg::N_DOM; d++) begin
      nxt_req[d] = st_ff.rst_sw[d] || st_ff.cfg_chg
        || !st_ff.cfg_ok; // [RULE11]
    end
    if (st_ff.mgr_need && !st_ff.lock_ok) begin
      nxt_req[xcp_pkg::DOM_CORE] = 1'b1; // [RULE11]
    end
  end

  assign dom.req = nxt_req;

  xcp_rst_bank #(
    .N(xcp_pkg::N_DOM),
    .STAGES(STAGES)
  ) u_rst_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .dom(dom.bank)
  ); // [RULE11]

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign tx_clk_src = st_ff.tx_src;
  assign rx_clk_src = st_ff.rx_src;
  assign core_clk_rate = st_ff.core_clk;
  assign mixed_mode_clock_manager_enable = st_ff.mgr_need;
  assign rx_elastic_bypass = st_ff.byp_eff;
  assign dom_rst_n = dom.rst_n;

endmodule : xcp_top

// ==== xcp_top_props.sv ====
// xcp_top_props: port-level checks for xcp_top
// assumes one aclk domain, bound to every xcp_top
`timescale 1ns/1ns

module xcp_top_props #(
  parameter int STAGES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mixed_mode_clock_manager_locked,
  input wire logic [1:0] tx_clk_src,
  input wire logic [1:0] rx_clk_src,
  input wire logic [1:0] core_clk_rate,
  input wire logic mixed_mode_clock_manager_enable,
  input wire logic rx_elastic_bypass,
  input wire logic [xcp_pkg::N_DOM-1:0] dom_rst_n
);
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic up_ff;
  // outputs still hold reset values on the first edge after release
  always_ff @(posedge aclk) up_ff <= aresetn;

  AST_CORE_PAIR: assert property (
    up_ff && tx_clk_src == 2'h0 |-> rx_clk_src == 2'h0 && core_clk_rate != 2'h0)
    else $error("core clock pairing broken");
  AST_RATE_312: assert property (
    core_clk_rate == 2'h2 |-> tx_clk_src == 2'h0
    && !mixed_mode_clock_manager_enable)
    else $error("312.5 rate without core source");
  AST_KR_BUF: assert property (
    rx_elastic_bypass |-> tx_clk_src == 2'h1)
    else $error("bypass outside newer r");
  AST_TX_USER: assert property (
    tx_clk_src == 2'h1 |-> core_clk_rate == 2'h0
    && !mixed_mode_clock_manager_enable)
    else $error("tx user clock with core clock");
  AST_RX_FOLLOW: assert property (
    up_ff && tx_clk_src == 2'h1 |->
    rx_clk_src == (rx_elastic_bypass ? 2'h2 : 2'h1))
    else $error("rx source wrong");
  AST_RST_HELD: assert property (
    !$past(aresetn) |-> dom_rst_n == '0)
    else $error("domain left reset early");
  AST_MGR_LOCK: assert property (
    (mixed_mode_clock_manager_enable
    && !mixed_mode_clock_manager_locked)[*5] |-> !dom_rst_n[0])
    else $error("core domain up without lock");
  for (genvar g = 0; g < xcp_pkg::N_DOM; g++) begin : g_dom
    AST_DOM_RELEASE: assert property (
      $rose(dom_rst_n[g]) |-> !$past(dom_rst_n[g]) && !$past(dom_rst_n[g], 2))
      else $error("domain release too fast");
  end
  cover property (rx_elastic_bypass);
  cover property (mixed_mode_clock_manager_locked && dom_rst_n[0]);
  cover property ($rose(dom_rst_n[1]));
endmodule : xcp_top_props

bind xcp_top xcp_top_props #(.STAGES(STAGES)) i_props (.aclk, .aresetn,
  .mixed_mode_clock_manager_locked, .tx_clk_src, .rx_clk_src, .core_clk_rate,
  .mixed_mode_clock_manager_enable, .rx_elastic_bypass, .dom_rst_n);
